// ### rtl/chopper_channel.sv
// one chopper channel: latch, dead time and bridge gating
`timescale 1ns/10ps
module chopper_channel (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // control
  input wire logic chop_tick,
  input wire logic sense_trip,
  input wire logic direction,
  input wire logic bridge_off,
  input wire logic hot,
  // bridge gates: upper a, lower b drive current a to b
  output logic [3:0] gate
);
  logic latch_reg;
  logic dir_reg;
  logic [7:0] dead_reg;
  logic [7:0] dead_next;
  wire dir_change = direction != dir_reg;
  wire dead_busy = dead_reg != 8'h00;
  wire conduct = latch_reg && !bridge_off && !hot && !dead_busy && !dir_change;
  assign dead_next = dir_change ? chopper_pkg::dead_load : (dead_busy ? dead_reg - 8'h01 : 8'h00);
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      latch_reg <= 1'b0;
      dir_reg <= 1'b0;
      dead_reg <= 8'h00;
      gate <= 4'h0;
    end else if (clk_en) begin
      // clear wins over set so a trip at the tick keeps the bridge off
      if (sense_trip) latch_reg <= 1'b0;
      else if (chop_tick) latch_reg <= 1'b1;
      dir_reg <= direction;
      dead_reg <= dead_next;
      gate <= conduct ? (dir_reg ? 4'b1001 : 4'b0110) : 4'h0;
    end
  end
  property p_trip_off;
    @(posedge core_clk) disable iff (reset) (clk_en && sense_trip) |=> !latch_reg;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("latch not cleared by trip");
  property p_tick_on;
    @(posedge core_clk) disable iff (reset) (clk_en && chop_tick && !sense_trip) |=> latch_reg;
  endproperty
  a_tick_on: assert property (p_tick_on) else $error("latch not set by tick");
  property p_coincide;
    @(posedge core_clk) disable iff (reset) (clk_en && chop_tick && sense_trip) |=> !latch_reg;
  endproperty
  a_coincide: assert property (p_coincide) else $error("tick beat trip");
  property p_off;
    @(posedge core_clk) disable iff (reset) (clk_en && (bridge_off || hot)) |=> gate == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("bridge on while off or hot");
  property p_dead;
    @(posedge core_clk) disable iff (reset) (clk_en && dir_change) |=> gate == 4'h0;
  endproperty
  a_dead: assert property (p_dead) else $error("no dead time on reversal");
  property p_legs;
    @(posedge core_clk) disable iff (reset) !(gate[3] && gate[1]) && !(gate[2] && gate[0]);
  endproperty
  a_legs: assert property (p_legs) else $error("leg cross conduction");
  property p_dir;
    @(posedge core_clk) disable iff (reset) (gate != 4'h0) |-> (gate == (dir_reg ? 4'b1001 : 4'b0110));
  endproperty
  a_dir: assert property (p_dir) else $error("wrong diagonal");
endmodule : chopper_channel

// ### rtl/chopper_pkg.sv
// constants for the dual chopper control block
package chopper_pkg;
  localparam int unsigned clk_hz = 50000000;
  // chopping rate in hertz, as printed 26.5 kHz
  localparam int unsigned chop_hz = 26500;
  localparam int unsigned chop_cycles = clk_hz / chop_hz;
  localparam logic [11:0] chop_last = 12'(chop_cycles - 1);
  // dead time when a direction changes, in ns
  localparam int unsigned dead_ns = 2000;
  localparam int unsigned dead_cycles = (dead_ns + 19) / 20;
  localparam logic [7:0] dead_load = 8'(dead_cycles);
  // register map
  localparam logic [3:0] ctrl_offs = 4'h0;
  localparam logic [3:0] status_offs = 4'h4;
  localparam int ctrl_dir1_bit = 0;
  localparam int ctrl_dir2_bit = 1;
  localparam int ctrl_off1_bit = 2;
  localparam int ctrl_off2_bit = 3;
  localparam logic [3:0] ctrl_reset_value = 4'hC;
endpackage : chopper_pkg

// ### rtl/dual_chopper_step_control.sv
// top of the dual chopper control with avalon register slave
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
// Notes on behaviour
// - one chopping clock feeds both channels' turn-on triggers.
// - every tick sets each channel latch unless that channel's comparator trips in the same cycle, bridge on.
// - comparator trip clears latch, bridge off until next tick.
// - fixed chop rate 26.5 kHz, on-time varies per cycle.
// - constant frequency with variable duty, no fixed off-time.
// - high bridge-off input forces all four transistors of that channel off.
// - direction high drives current output a to b, low reverses.
// - direction change inserts dead time before the new diagonal.
// - over-temperature forces all outputs off until cooled about 20 degrees.
module dual_chopper_step_control (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // sense comparators and thermal flag
  input wire logic chan1_sense_trip,
  input wire logic chan2_sense_trip,
  input wire logic over_temp,
  // bridges
  output logic [3:0] chan1_gate,
  output logic [3:0] chan2_gate
);
  // chopping clock shared by both channels
  logic [11:0] chop_cnt_reg;
  logic [11:0] chop_cnt_next;

  // register slave state
  logic [3:0] ctrl_reg;
  logic [3:0] ctrl_next;
  logic ack_reg;
  logic [31:0] readdata_next;

  // chopping clock decode
  wire chop_tick = chop_cnt_reg == chopper_pkg::chop_last;
  assign chop_cnt_next = chop_tick ? 12'h000 : chop_cnt_reg + 12'h001;

  // bus decode
  wire request = read || write;
  wire access = request && !ack_reg;
  wire commit = request && ack_reg;
  wire sel_ctrl = address == chopper_pkg::ctrl_offs;
  wire sel_status = address == chopper_pkg::status_offs;
  wire ctrl_wr = commit && write && sel_ctrl;

  // read words
  wire chan1_on = chan1_gate != 4'h0;
  wire chan2_on = chan2_gate != 4'h0;
  wire [31:0] status_word = {24'h000000, chan2_on, chan1_on, over_temp, chop_tick, ctrl_reg};
  wire [31:0] ctrl_word = {28'h0000000, ctrl_reg};
  wire [31:0] read_word = sel_ctrl ? ctrl_word : (sel_status ? status_word : 32'h00000000);

  // next values
  assign ctrl_next = ctrl_wr ? writedata[3:0] : ctrl_reg;
  assign readdata_next = (access && read) ? read_word : readdata;

  // one wait state per access keeps read data registered;
  // a write lands only at the edge where the master sees waitrequest low
  assign waitrequest = access;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      chop_cnt_reg <= 12'h000;
    end else if (clk_en) begin
      chop_cnt_reg <= chop_cnt_next;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= chopper_pkg::ctrl_reset_value;
    end else if (clk_en) begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else if (clk_en) begin
      ack_reg <= access;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      readdata <= 32'h00000000;
    end else if (clk_en) begin
      readdata <= readdata_next;
    end
  end

  // the thermal hysteresis lives in the sensor; over_temp is already held
  chopper_channel u_chan1 (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .chop_tick(chop_tick),
    .sense_trip(chan1_sense_trip),
    .direction(ctrl_reg[chopper_pkg::ctrl_dir1_bit]),
    .bridge_off(ctrl_reg[chopper_pkg::ctrl_off1_bit]),
    .hot(over_temp),
    .gate(chan1_gate)
  );

  chopper_channel u_chan2 (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .chop_tick(chop_tick),
    .sense_trip(chan2_sense_trip),
    .direction(ctrl_reg[chopper_pkg::ctrl_dir2_bit]),
    .bridge_off(ctrl_reg[chopper_pkg::ctrl_off2_bit]),
    .hot(over_temp),
    .gate(chan2_gate)
  );

  property p_wait_first;
    @(posedge core_clk) disable iff (reset) (request && !ack_reg) |-> waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait state on new access");

  property p_wait_done;
    @(posedge core_clk) disable iff (reset) (clk_en && access) |=> !waitrequest;
  endproperty
  a_wait_done: assert property (p_wait_done) else $error("access not answered after one wait");

  property p_write_lands;
    @(posedge core_clk) disable iff (reset) (clk_en && ctrl_wr) |=> ctrl_reg == $past(writedata[3:0]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("control write lost");

  property p_ctrl_hold;
    @(posedge core_clk) disable iff (reset) (clk_en && !ctrl_wr) |=> $stable(ctrl_reg);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without write");

  property p_read_data;
    @(posedge core_clk) disable iff (reset) (clk_en && access && read) |=> readdata == $past(read_word);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not captured");

  property p_unmapped;
    @(posedge core_clk) disable iff (reset) (clk_en && access && read && !sel_ctrl && !sel_status) |=> readdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_status_hot;
    @(posedge core_clk) disable iff (reset) (clk_en && access && read && sel_status) |=> readdata[5] == $past(over_temp);
  endproperty
  a_status_hot: assert property (p_status_hot) else $error("status misses thermal flag");

  property p_freeze;
    @(posedge core_clk) disable iff (reset) !clk_en |=> ($stable(chop_cnt_reg) && $stable(ctrl_reg) && $stable(chan1_gate));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while enable low");

  property p_cnt_range;
    @(posedge core_clk) disable iff (reset) chop_cnt_reg <= chopper_pkg::chop_last;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("chop counter out of range");

  property p_shared_tick;
    @(posedge core_clk) disable iff (reset) (clk_en && chop_tick && !chan1_sense_trip && !chan2_sense_trip) |=> (u_chan1.latch_reg && u_chan2.latch_reg);
  endproperty
  a_shared_tick: assert property (p_shared_tick) else $error("tick did not reach both channels");

  property p_chan_off;
    @(posedge core_clk) disable iff (reset) (clk_en && ctrl_reg[chopper_pkg::ctrl_off1_bit]) |=> chan1_gate == 4'h0;
  endproperty
  a_chan_off: assert property (p_chan_off) else $error("channel one on while switched off");

  property p_hot;
    @(posedge core_clk) disable iff (reset) (clk_en && over_temp) |=> (chan1_gate == 4'h0 && chan2_gate == 4'h0);
  endproperty
  a_hot: assert property (p_hot) else $error("outputs on while hot");
  property p_period;
    @(posedge core_clk) disable iff (reset) (clk_en && chop_tick) |=> chop_cnt_reg == 12'h000;
  endproperty
  a_period: assert property (p_period) else $error("chop counter not restarted");
endmodule : dual_chopper_step_control

// ### verification/step_sequencer.sv
// host step sequencer producing control words
`timescale 1ns/10ps
module step_sequencer (
  // step select
  input wire logic half_mode,
  input wire logic [2:0] index,
  // control word: off2 off1 dir2 dir1
  output logic [3:0] ctrl_word
);
  localparam logic [3:0] full_tab [4] = '{4'h3, 4'h2, 4'h0, 4'h1};
  localparam logic [3:0] half_tab [8] = '{4'h3, 4'h7, 4'h2, 4'hA, 4'h0, 4'h4, 4'h1, 4'h9};
  assign ctrl_word = half_mode ? half_tab[index] : full_tab[index[1:0]];
endmodule : step_sequencer

// ### verification/testbench.sv
// self-checking bench for the dual chopper control
`timescale 1ns/10ps
module testbench;
  logic core_clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, trip1 = 1'b0, trip2 = 1'b0, hot = 1'b0;
  logic half_mode = 1'b0, waitrequest, clk_en = 1'b1;
  logic [2:0] index = 3'h0;
  logic [3:0] address = 4'h0, ctrl_word, gate1, gate2;
  logic [31:0] writedata = 32'h0, readdata, q, seed = 32'h477A;
  int err_count = 0, checks_done = 0;
  always #10 core_clk = ~core_clk;
  dual_chopper_step_control dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .chan1_sense_trip(trip1), .chan2_sense_trip(trip2), .over_temp(hot), .chan1_gate(gate1), .chan2_gate(gate2));
  step_sequencer host (.half_mode(half_mode), .index(index), .ctrl_word(ctrl_word));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  // expected gates of one channel from the control word
  function automatic logic [3:0] model(input int c, input int ch);
    if ((c >> (ch + 2)) & 1) return 4'h0;
    return ((c >> ch) & 1) ? 4'h9 : 4'h6;
  endfunction : model
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one idle edge first, so back-to-back calls never drive a strobe twice in a step
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    if (waitrequest !== 1'b0) err_count++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic summarize;
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    chk(gate1 | gate2, 32'h0);
    bus(1'b0, chopper_pkg::ctrl_offs, 32'h0);
    chk(q, 32'(chopper_pkg::ctrl_reset_value));
    bus(1'b1, 4'h8, 32'hF);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 4 + 4 * m; i++) begin
        half_mode <= m[0];
        index <= i[2:0];
        @(posedge core_clk);
        bus(1'b1, chopper_pkg::ctrl_offs, {28'h0, ctrl_word});
        repeat (2000) @(posedge core_clk);
        chk(gate1, model(ctrl_word, 0));
        chk(gate2, model(ctrl_word, 1));
      end
    end
    bus(1'b1, chopper_pkg::ctrl_offs, 32'h3);
    repeat (2000) @(posedge core_clk);
    seed = xs(seed);
    trip1 <= 1'b1;
    repeat (3 + seed[3:0]) @(posedge core_clk);
    chk(gate1, 32'h0);
    chk(gate2, 32'h9);
    trip1 <= 1'b0;
    hot <= 1'b1;
    repeat (3 + seed[7:4]) @(posedge core_clk);
    chk(gate1 | gate2, 32'h0);
    bus(1'b0, chopper_pkg::status_offs, 32'h0);
    chk({q[5], q[3:0]}, 32'h13);
    hot <= 1'b0;
    repeat (2000) @(posedge core_clk);
    chk(gate1, 32'h9);
    // enable low must freeze the bridges even against a trip
    clk_en <= 1'b0;
    trip1 <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk(gate1, 32'h9);
    trip1 <= 1'b0;
    clk_en <= 1'b1;
    summarize;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    summarize;
  end
endmodule : testbench
